// ---- hw/pac_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pac_defs.vh"
module pac_top #(
  parameter [19:0] BREAK_CYC = `PAC_BREAK_CYC,
  parameter [19:0] EXIT_CYC = `PAC_EXIT_CYC,
  parameter [31:0] POLL_CYC = `PAC_POLL_CYC,
  parameter [31:0] SECOND_CYC = `PAC_SECOND_CYC
) (
  input wire MCLK,
  input wire EXTERNAL_RESET_INPUT,
  input wire EXT_RESET_IN,
  input wire PROG_ENABLE_N,
  input wire PROG_CLOCK_IN,
  input wire PROG_DATA_IN,
  output wire PROG_DATA_OUT,
  output wire TEST_MODE,
  output wire PROG_MODE,
  output reg WM_UNLOCKED,
  input wire [63:0] WM_KEY_REF,
  input wire [63:0] ISP_KEY_REF,
  input wire [127:0] BOOT_TAIL,
  input wire [7:0] WAIT_BYTE,
  input wire TWOWIRE_CLK1_PAD,
  input wire TWOWIRE_CLK2_PAD,
  input wire [2:0] ISP_REQUEST,
  input wire ISP_CMD_VALID,
  input wire [7:0] ISP_CMD,
  input wire [63:0] ISP_ARG,
  output reg ISP_ACCEPT,
  output reg ISP_REFUSE,
  output reg ISP_UNLOCKED,
  output reg BOOT_TO_USER,
  output reg BOOT_TO_ISP,
  output reg FLASH_ERASE_MAIN,
  output reg FLASH_ERASE_ALL,
  output reg FLASH_CMD,
  output reg [7:0] FLASH_CMD_CODE,
  output reg FLASH_INFO_WR,
  output reg [7:0] FLASH_INFO_ADDR,
  output reg [7:0] FLASH_INFO_DATA
);
  localparam [11:0] VERIFY_CYC = `PAC_VERIFY_CYC;
  localparam [1:0] B_SETTLE = 2'h0, B_POLL = 2'h1, B_USER = 2'h2, B_ISP = 2'h3;
  localparam IX_PIN = 0, IX_EN = 1, IX_CLK = 2, IX_DIN = 3, IX_P1 = 4, IX_P2 = 5;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  reg [5:0] sync1;
  reg [5:0] sync2;
  reg clk_q;
  wire [5:0] raw_in = {TWOWIRE_CLK2_PAD, TWOWIRE_CLK1_PAD, PROG_DATA_IN,
                       PROG_CLOCK_IN, PROG_ENABLE_N, EXT_RESET_IN};

  // all pins but clock and data idle high, so the chain resets high to avoid a false break
  always @(posedge MCLK or negedge EXTERNAL_RESET_INPUT) begin
    if (!EXTERNAL_RESET_INPUT) begin
      sync1 <= 6'h3F;
      sync2 <= 6'h3F;
      clk_q <= 1'b1;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      clk_q <= sync2[IX_CLK];
    end
  end

  // ************************************************************
  // entry decoder on the reset pin
  // ************************************************************
  pac_entry #(
    .BREAK_CYC(BREAK_CYC),
    .EXIT_CYC(EXIT_CYC)
  ) u_entry (
    .clk(MCLK),
    .rst_n(EXTERNAL_RESET_INPUT),
    .pin(sync2[IX_PIN]),
    .test_mode(TEST_MODE),
    .writer_mode(PROG_MODE)
  );

  // ************************************************************
  // shared state
  // ************************************************************
  reg [255:0] info_done;
  reg all_erased;
  reg [6:0] bit_cnt;
  reg [7:0] cmd;
  reg [63:0] rx_sr;
  reg [7:0] tx_sr;
  reg [11:0] vfy_cnt;
  reg [63:0] vfy_key;
  reg last_pass;
  reg refused;
  reg [1:0] boot_state;
  reg [31:0] boot_cnt;
  reg [2:0] wait_ones;
  reg [15:0] byte_blank;
  integer k;

  wire clk_rise = sync2[IX_CLK] & ~clk_q;
  wire port_on = PROG_MODE & ~sync2[IX_EN];
  wire [6:0] next_bit_cnt = bit_cnt + 7'h01;
  wire [63:0] next_rx = {rx_sr[62:0], sync2[IX_DIN]};
  wire [7:0] status = {vfy_cnt != 12'h000, WM_UNLOCKED, last_pass, refused, 4'h0};
  wire isp_live = (boot_state == B_ISP) & ~PROG_MODE;

  // one-time and maker-byte gating of info block writes
  function info_ok;
    input [7:0] addr;
    input from_wm;
    input erased;
    input done;
    begin
      if (addr < `PAC_INFO_MU_BASE) info_ok = from_wm & erased;
      else if (addr < `PAC_INFO_USER_BASE) info_ok = (from_wm & erased) | ~done;
      else info_ok = ~done;
    end
  endfunction

  assign PROG_DATA_OUT = tx_sr[7];

  // ************************************************************
  // programming port and serial programming command engine
  // ************************************************************
  // writer traffic has priority; isp commands are refused while writer mode is on
  always @(posedge MCLK or negedge EXTERNAL_RESET_INPUT) begin
    if (!EXTERNAL_RESET_INPUT) begin
      info_done <= {256{1'b0}};
      all_erased <= 1'b0;
      bit_cnt <= 7'h00;
      cmd <= 8'h00;
      rx_sr <= 64'h0;
      tx_sr <= `PAC_STATUS_RST;
      vfy_cnt <= 12'h000;
      vfy_key <= 64'h0;
      last_pass <= 1'b0;
      refused <= 1'b0;
      WM_UNLOCKED <= 1'b0;
      ISP_UNLOCKED <= 1'b0;
      ISP_ACCEPT <= 1'b0;
      ISP_REFUSE <= 1'b0;
      FLASH_ERASE_MAIN <= 1'b0;
      FLASH_ERASE_ALL <= 1'b0;
      FLASH_CMD <= 1'b0;
      FLASH_CMD_CODE <= 8'h00;
      FLASH_INFO_WR <= 1'b0;
      FLASH_INFO_ADDR <= 8'h00;
      FLASH_INFO_DATA <= 8'h00;
    end else begin
      ISP_ACCEPT <= 1'b0;
      ISP_REFUSE <= 1'b0;
      FLASH_ERASE_MAIN <= 1'b0;
      FLASH_ERASE_ALL <= 1'b0;
      FLASH_CMD <= 1'b0;
      FLASH_INFO_WR <= 1'b0;
      // verify runs its full time whether or not the key matches
      if (vfy_cnt != 12'h000) begin
        vfy_cnt <= vfy_cnt - 12'h001;
        if (vfy_cnt == 12'h001) begin
          last_pass <= (vfy_key == WM_KEY_REF);
          if (vfy_key == WM_KEY_REF) WM_UNLOCKED <= 1'b1;
        end
      end
      if (!PROG_MODE) WM_UNLOCKED <= 1'b0;
      if (!port_on) begin
        bit_cnt <= 7'h00;
      end else if (clk_rise) begin
        rx_sr <= next_rx;
        bit_cnt <= next_bit_cnt;
        if (next_bit_cnt[2:0] == 3'h0) tx_sr <= status;
        else tx_sr <= {tx_sr[6:0], 1'b0};
        if (next_bit_cnt == 7'h08) begin
          cmd <= next_rx[7:0];
          refused <= 1'b0;
          if (vfy_cnt != 12'h000) refused <= 1'b1;
          else if (next_rx[7:0] == `PAC_CMD_ERASE_MAIN) begin
            FLASH_ERASE_MAIN <= 1'b1;
          end else if (next_rx[7:0] == `PAC_CMD_ERASE_ALL) begin
            FLASH_ERASE_ALL <= 1'b1;
            all_erased <= 1'b1;
            info_done <= {256{1'b0}};
          end else if (next_rx[7:0] == `PAC_CMD_READ_VERIFY) begin
            refused <= 1'b0;
          end else if (!WM_UNLOCKED) begin
            refused <= 1'b1;
          end else if (next_rx[7:0] != `PAC_CMD_INFO_WRITE) begin
            FLASH_CMD <= 1'b1;
            FLASH_CMD_CODE <= next_rx[7:0];
            all_erased <= 1'b0;
          end
        end
        if (next_bit_cnt == 7'h48 && cmd == `PAC_CMD_READ_VERIFY && !refused) begin
          vfy_cnt <= VERIFY_CYC;
          vfy_key <= next_rx;
        end
        if (next_bit_cnt == 7'h18 && cmd == `PAC_CMD_INFO_WRITE && WM_UNLOCKED) begin
          if (info_ok(next_rx[15:8], 1'b1, all_erased, info_done[next_rx[15:8]])) begin
            FLASH_INFO_WR <= 1'b1;
            FLASH_INFO_ADDR <= next_rx[15:8];
            FLASH_INFO_DATA <= next_rx[7:0];
            if (next_rx[15:8] >= `PAC_INFO_MU_BASE) info_done[next_rx[15:8]] <= 1'b1;
          end else refused <= 1'b1;
        end
      end
      if (isp_live && ISP_CMD_VALID) begin
        if (ISP_CMD == `PAC_CMD_READ_VERIFY) begin
          ISP_ACCEPT <= 1'b1;
          if (ISP_ARG == ISP_KEY_REF) ISP_UNLOCKED <= 1'b1;
        end else if (!ISP_UNLOCKED) begin
          ISP_REFUSE <= 1'b1;
        end else if (ISP_CMD == `PAC_CMD_INFO_WRITE) begin
          if (info_ok(ISP_ARG[15:8], 1'b0, all_erased, info_done[ISP_ARG[15:8]])) begin
            ISP_ACCEPT <= 1'b1;
            FLASH_INFO_WR <= 1'b1;
            FLASH_INFO_ADDR <= ISP_ARG[15:8];
            FLASH_INFO_DATA <= ISP_ARG[7:0];
            info_done[ISP_ARG[15:8]] <= 1'b1;
          end else ISP_REFUSE <= 1'b1;
        end else begin
          ISP_ACCEPT <= 1'b1;
          FLASH_CMD <= 1'b1;
          FLASH_CMD_CODE <= ISP_CMD;
        end
      end else if (!isp_live && ISP_CMD_VALID) begin
        ISP_REFUSE <= 1'b1;
      end
    end
  end

  // ************************************************************
  // start-up decision
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_blank
      // each tail byte must read all ones
      always @* byte_blank[g] = &BOOT_TAIL[8*g+7:8*g];
    end
  endgenerate

  // seconds of extra wait, one per set bit in the low six bits
  always @* begin
    wait_ones = 3'h0;
    for (k = 0; k < 6; k = k + 1) begin
      wait_ones = wait_ones + {2'h0, WAIT_BYTE[k]};
    end
  end

  wire [31:0] wait_limit = POLL_CYC + ({29'h0, wait_ones} * SECOND_CYC);
  wire pad_hit = (WAIT_BYTE[`PAC_WAIT_PAD2_BIT] & ~sync2[IX_P2]) |
                 (WAIT_BYTE[`PAC_WAIT_PAD1_BIT] & ~sync2[IX_P1]);

  // settle gives the pad synchronisers time to fill before the check
  always @(posedge MCLK or negedge EXTERNAL_RESET_INPUT) begin
    if (!EXTERNAL_RESET_INPUT) begin
      boot_state <= B_SETTLE;
      boot_cnt <= 32'h0;
      BOOT_TO_USER <= 1'b0;
      BOOT_TO_ISP <= 1'b0;
    end else begin
      case (boot_state)
        B_SETTLE: begin
          boot_cnt <= boot_cnt + 32'h1;
          if (boot_cnt == 32'h3) begin
            boot_cnt <= 32'h0;
            if (!(&byte_blank)) begin
              boot_state <= B_USER;
              BOOT_TO_USER <= 1'b1;
            end else if (pad_hit) begin
              boot_state <= B_ISP;
              BOOT_TO_ISP <= 1'b1;
            end else boot_state <= B_POLL;
          end
        end
        B_POLL: begin
          boot_cnt <= boot_cnt + 32'h1;
          if (|ISP_REQUEST) begin
            boot_state <= B_ISP;
            BOOT_TO_ISP <= 1'b1;
          end else if (boot_cnt >= wait_limit) begin
            boot_state <= B_USER;
            BOOT_TO_USER <= 1'b1;
          end
        end
        B_USER, B_ISP: boot_state <= boot_state;
        default: boot_state <= B_SETTLE;
      endcase
    end
  end
endmodule // pac_top
`default_nettype wire

// ---- common/pac_defs.vh ----
`ifndef PAC_DEFS_VH
`define PAC_DEFS_VH
// ************************************************************
// clock and timing figures
// ************************************************************
`define PAC_CLK_MHZ 200
`define PAC_T_CYC 16
`define PAC_BREAK_US 4000
`define PAC_EXIT_US 2000
`define PAC_POLL_US 10000
`define PAC_SECOND_US 1000000
`define PAC_VERIFY_US 10
`define PAC_BREAK_CYC (`PAC_BREAK_US * `PAC_CLK_MHZ)
`define PAC_EXIT_CYC (`PAC_EXIT_US * `PAC_CLK_MHZ)
`define PAC_POLL_CYC (`PAC_POLL_US * `PAC_CLK_MHZ)
`define PAC_SECOND_CYC (`PAC_SECOND_US * `PAC_CLK_MHZ)
`define PAC_VERIFY_CYC (`PAC_VERIFY_US * `PAC_CLK_MHZ)
// ************************************************************
// duty-cycle symbol windows, low time and period in units of T
// ************************************************************
`define PAC_BIT_T 16
`define PAC_ZERO_MIN_T 2
`define PAC_ZERO_MAX_T 4
`define PAC_ONE_MIN_T 5
`define PAC_ONE_MAX_T 7
`define PAC_SYNC_MIN_T 8
`define PAC_SYNC_MAX_T 10
`define PAC_TERM_MIN_T 11
`define PAC_TERM_MAX_T 13
`define PAC_PER_MIN_T 14
`define PAC_PER_MAX_T 18
`define PAC_SYNC_BITS 3
`define PAC_ENTRY_KEY 8'hA5
`define PAC_ENTRY_TEST 8'h3C
`define PAC_ENTRY_WRITER 8'hC3
// ************************************************************
// programming port commands and info block layout
// ************************************************************
`define PAC_CMD_ERASE_MAIN 8'h01
`define PAC_CMD_ERASE_ALL 8'h02
`define PAC_CMD_READ_VERIFY 8'h03
`define PAC_CMD_INFO_WRITE 8'h04
`define PAC_INFO_MU_BASE 8'h40
`define PAC_INFO_USER_BASE 8'h44
`define PAC_WAIT_PAD1_BIT 6
`define PAC_WAIT_PAD2_BIT 7
`define PAC_STATUS_RST 8'h00
`endif

// ---- hw/pac_entry.v ----
`timescale 1ns/1ps
`default_nettype none
`include "pac_defs.vh"
module pac_entry #(
  parameter [19:0] BREAK_CYC = `PAC_BREAK_CYC,
  parameter [19:0] EXIT_CYC = `PAC_EXIT_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire pin,
  output reg test_mode,
  output reg writer_mode
);
  localparam [19:0] ZMIN = `PAC_ZERO_MIN_T * `PAC_T_CYC;
  localparam [19:0] ZMAX = `PAC_ZERO_MAX_T * `PAC_T_CYC;
  localparam [19:0] OMIN = `PAC_ONE_MIN_T * `PAC_T_CYC;
  localparam [19:0] OMAX = `PAC_ONE_MAX_T * `PAC_T_CYC;
  localparam [19:0] SMIN = `PAC_SYNC_MIN_T * `PAC_T_CYC;
  localparam [19:0] SMAX = `PAC_SYNC_MAX_T * `PAC_T_CYC;
  localparam [19:0] TMIN = `PAC_TERM_MIN_T * `PAC_T_CYC;
  localparam [19:0] TMAX = `PAC_TERM_MAX_T * `PAC_T_CYC;
  localparam [19:0] PMIN = `PAC_PER_MIN_T * `PAC_T_CYC;
  localparam [19:0] PMAX = `PAC_PER_MAX_T * `PAC_T_CYC;
  localparam [4:0] NSYNC = `PAC_SYNC_BITS;
  localparam [4:0] LAST = NSYNC + 5'h10;
  localparam [4:0] DONE = LAST + 5'h01;
  localparam [2:0] S_IDLE = 3'h0, S_BREAK = 3'h1, S_LOW = 3'h2;
  localparam [2:0] S_HIGH = 3'h3, S_ACTIVE = 3'h4, S_ERR = 3'h5;
  localparam [1:0] SY_ZERO = 2'h0, SY_ONE = 2'h1, SY_SYNC = 2'h2, SY_TERM = 2'h3;

  reg [2:0] state;
  reg pin_q;
  reg [19:0] run_cnt;
  reg [19:0] per_cnt;
  reg [4:0] idx;
  reg [15:0] data;
  reg [1:0] sym;
  reg sym_valid;
  reg sym_ok;
  wire rise = pin & ~pin_q;
  wire fall = ~pin & pin_q;

  // classify the low time that just ended into one of four symbols
  always @* begin
    sym = SY_ZERO;
    sym_valid = 1'b1;
    if (run_cnt >= ZMIN && run_cnt <= ZMAX) sym = SY_ZERO;
    else if (run_cnt >= OMIN && run_cnt <= OMAX) sym = SY_ONE;
    else if (run_cnt >= SMIN && run_cnt <= SMAX) sym = SY_SYNC;
    else if (run_cnt >= TMIN && run_cnt <= TMAX) sym = SY_TERM;
    else sym_valid = 1'b0;
    if (idx < NSYNC) sym_ok = sym_valid & (sym == SY_SYNC);
    else if (idx < LAST) sym_ok = sym_valid & (sym == SY_ZERO || sym == SY_ONE);
    else sym_ok = sym_valid & (sym == SY_TERM);
  end

  // run and period counters saturate so a stuck pin never wraps
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b1;
      run_cnt <= 20'h00000;
      per_cnt <= 20'h00000;
    end else begin
      pin_q <= pin;
      if (pin != pin_q) run_cnt <= 20'h00001;
      else if (run_cnt != 20'hFFFFF) run_cnt <= run_cnt + 20'h00001;
      if (fall) per_cnt <= 20'h00001;
      else if (per_cnt != 20'hFFFFF) per_cnt <= per_cnt + 20'h00001;
    end
  end

  // sequence tracker; any mismatch parks in error until the next break
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      idx <= 5'h00;
      data <= 16'h0000;
      test_mode <= 1'b0;
      writer_mode <= 1'b0;
    end else if (pin && !rise && run_cnt > EXIT_CYC) begin // a rise still shows the low run
      test_mode <= 1'b0;
      writer_mode <= 1'b0;
      state <= S_IDLE;
    end else if (!pin && !fall && run_cnt > BREAK_CYC && state != S_ACTIVE) begin
      state <= S_BREAK;
      idx <= 5'h00;
    end else begin
      case (state)
        S_BREAK: begin
          if (rise) state <= S_HIGH;
        end
        S_HIGH: begin
          if (fall) begin
            if (idx == DONE) begin
              // pin back low after the terminal bit holds the mode
              if (data == {`PAC_ENTRY_KEY, `PAC_ENTRY_TEST}) begin
                test_mode <= 1'b1;
                state <= S_ACTIVE;
              end else if (data == {`PAC_ENTRY_KEY, `PAC_ENTRY_WRITER}) begin
                writer_mode <= 1'b1;
                state <= S_ACTIVE;
              end else state <= S_ERR;
            end else if (idx != 5'h00 && (per_cnt < PMIN || per_cnt > PMAX)) begin
              state <= S_ERR;
            end else state <= S_LOW;
          end else if (idx != 5'h00 && idx != DONE && per_cnt > PMAX) begin
            state <= S_ERR;
          end
        end
        S_LOW: begin
          if (rise) begin
            if (sym_ok) begin
              idx <= idx + 5'h01;
              if (idx >= NSYNC && idx < LAST) data <= {data[14:0], sym == SY_ONE};
              state <= S_HIGH;
            end else state <= S_ERR;
          end
        end
        S_IDLE, S_ACTIVE, S_ERR: state <= state;
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // pac_entry
`default_nettype wire

// ---- verif/pac_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// port checker
// ************************************************************
module pac_top_monitor #(
  parameter [19:0] EXIT_CYC = 20'h003E8
) (
  input wire logic MCLK,
  input wire logic EXTERNAL_RESET_INPUT,
  input wire logic EXT_RESET_IN,
  input wire logic TEST_MODE,
  input wire logic PROG_MODE,
  input wire logic WM_UNLOCKED,
  input wire logic [63:0] ISP_KEY_REF,
  input wire logic [127:0] BOOT_TAIL,
  input wire logic [7:0] WAIT_BYTE,
  input wire logic TWOWIRE_CLK2_PAD,
  input wire logic ISP_CMD_VALID,
  input wire logic [7:0] ISP_CMD,
  input wire logic [63:0] ISP_ARG,
  input wire logic ISP_ACCEPT,
  input wire logic ISP_REFUSE,
  input wire logic ISP_UNLOCKED,
  input wire logic BOOT_TO_USER,
  input wire logic BOOT_TO_ISP
);
  logic [20:0] high_cnt;
  wire blank = &BOOT_TAIL;
  // high time of the reset pin, saturating so it never wraps
  always @(posedge MCLK or negedge EXTERNAL_RESET_INPUT) begin
    if (!EXTERNAL_RESET_INPUT) high_cnt <= 21'h0;
    else if (!EXT_RESET_IN) high_cnt <= 21'h0;
    else if (high_cnt != {1'b0, EXIT_CYC} + 21'h9) high_cnt <= high_cnt + 21'h1;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!EXTERNAL_RESET_INPUT);
  sequence s_isp_req; ISP_CMD_VALID && BOOT_TO_ISP && !PROG_MODE; endsequence
  sequence s_answer; ISP_ACCEPT || ISP_REFUSE; endsequence
  property p_isp_answer; s_isp_req |=> s_answer; endproperty
  a_isp_answer: assert property (p_isp_answer) else $error("isp request unanswered");
  property p_ans_cause; s_answer |-> $past(ISP_CMD_VALID) && !(ISP_ACCEPT && ISP_REFUSE); endproperty
  a_ans_cause: assert property (p_ans_cause) else $error("stray isp answer");
  property p_locked; ISP_CMD_VALID && !ISP_UNLOCKED && ISP_CMD != 8'h03 |=> !ISP_ACCEPT; endproperty
  a_locked: assert property (p_locked) else $error("locked isp accepted");
  property p_unlock;
    $rose(ISP_UNLOCKED) |-> $past(ISP_CMD_VALID && ISP_CMD == 8'h03 && ISP_ARG == ISP_KEY_REF);
  endproperty
  a_unlock: assert property (p_unlock) else $error("isp unlock without key");
  property p_user; $rose(EXTERNAL_RESET_INPUT) && !blank |-> ##[1:10] BOOT_TO_USER; endproperty
  a_user: assert property (p_user) else $error("no user jump");
  property p_isp_blank; $rose(BOOT_TO_ISP) |-> blank && !BOOT_TO_USER; endproperty
  a_isp_blank: assert property (p_isp_blank) else $error("isp with used tail");
  property p_pad;
    $rose(EXTERNAL_RESET_INPUT) && blank && WAIT_BYTE[7] && !TWOWIRE_CLK2_PAD |-> ##[1:12] BOOT_TO_ISP;
  endproperty
  a_pad: assert property (p_pad) else $error("pad request ignored");
  property p_exit; high_cnt == {1'b0, EXIT_CYC} + 21'h8 |-> !TEST_MODE && !PROG_MODE; endproperty
  a_exit: assert property (p_exit) else $error("mode kept while pin high");
  property p_mode_low; $rose(TEST_MODE || PROG_MODE) |-> !EXT_RESET_IN; endproperty
  a_mode_low: assert property (p_mode_low) else $error("mode set with pin high");
  property p_wm_unlock; $rose(WM_UNLOCKED) |-> PROG_MODE; endproperty
  a_wm_unlock: assert property (p_wm_unlock) else $error("port unlocked outside mode");
  property p_mode_excl; !(TEST_MODE && PROG_MODE); endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("both modes");
endmodule // pac_top_monitor
bind pac_top pac_top_monitor #(.EXIT_CYC(EXIT_CYC)) mon_u (.MCLK(MCLK), .EXTERNAL_RESET_INPUT(EXTERNAL_RESET_INPUT),
  .EXT_RESET_IN(EXT_RESET_IN), .TEST_MODE(TEST_MODE), .PROG_MODE(PROG_MODE),
  .WM_UNLOCKED(WM_UNLOCKED), .ISP_KEY_REF(ISP_KEY_REF), .BOOT_TAIL(BOOT_TAIL),
  .WAIT_BYTE(WAIT_BYTE), .TWOWIRE_CLK2_PAD(TWOWIRE_CLK2_PAD), .ISP_CMD_VALID(ISP_CMD_VALID),
  .ISP_CMD(ISP_CMD), .ISP_ARG(ISP_ARG), .ISP_ACCEPT(ISP_ACCEPT), .ISP_REFUSE(ISP_REFUSE),
  .ISP_UNLOCKED(ISP_UNLOCKED), .BOOT_TO_USER(BOOT_TO_USER), .BOOT_TO_ISP(BOOT_TO_ISP));
`default_nettype wire

// ---- verif/pac_prog_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// external programmer: entry stream and serial port
// ************************************************************
module pac_prog_model (
  input wire logic mclk,
  output logic ext_reset,
  output logic prog_en_n,
  output logic prog_clk,
  output logic prog_din
);
  // pin idles high, serial clock stands low outside frames
  initial begin
    ext_reset = 1'b1;
    prog_en_n = 1'b1;
    prog_clk = 1'b0;
    prog_din = 1'b0;
  end
  // one symbol of sixteen units, k units low
  task automatic sym(input int k);
    @(posedge mclk) ext_reset <= 1'b0;
    repeat (k * 16) @(posedge mclk);
    ext_reset <= 1'b1;
    repeat ((16 - k) * 16 - 1) @(posedge mclk);
  endtask
  // optional break, sync, two bytes, terminal, then low to hold
  task automatic entry(input logic brk, input logic [15:0] bytes);
    int i;
    if (brk) begin
      @(posedge mclk) ext_reset <= 1'b0;
      repeat (2100) @(posedge mclk);
    end
    @(posedge mclk) ext_reset <= 1'b1;
    repeat (511) @(posedge mclk);
    repeat (3) sym(9);
    for (i = 15; i >= 0; i--) sym(bytes[i] ? 6 : 3);
    sym(12);
    @(posedge mclk) ext_reset <= 1'b0;
  endtask
  task automatic hold_high(input int n);
    @(posedge mclk) ext_reset <= 1'b1;
    repeat (n) @(posedge mclk);
  endtask
  task automatic en(input logic v);
    @(posedge mclk) prog_en_n <= v;
  endtask
  // enable pulse restarts the bit count so the next byte is a command
  task automatic reframe;
    en(1'b1);
    repeat (4) @(posedge mclk);
    en(1'b0);
    repeat (4) @(posedge mclk);
  endtask
  // byte MSB first on a 48 ns clock; offset keeps edges off mclk
  task automatic send_byte(input logic [7:0] b);
    int i;
    #0.3;
    for (i = 7; i >= 0; i--) begin
      prog_din = b[i];
      #24 prog_clk = 1'b1;
      #24 prog_clk = 1'b0;
    end
    prog_din = ~prog_din; // released line shows no stale bit
  endtask
endmodule // pac_prog_model
`default_nettype wire

// ---- verif/test_pac_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// bench top
// ************************************************************
module test_pac_top;
  logic mclk, external_reset_input, valid, pad1, pad2;
  logic [63:0] isp_key, wm_key, arg;
  logic [127:0] tail;
  logic [7:0] wait_b, cmd, n_main, n_all, n_cmd, n_info;
  logic [2:0] req;
  logic [1:0] notes[$];
  logic [31:0] seed;
  int error_cnt, total_checks, cyc;
  wire pin, pe_n, pclk, pdin, test_m, prog_m, wm_unl, acc, rfs, isp_unl, to_user, to_isp;
  wire ers_main, ers_all, fcmd, info_wr, pdout;
  wire [7:0] fcode, faddr, fdata;
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  pac_prog_model prog_u (.mclk(mclk), .ext_reset(pin), .prog_en_n(pe_n), .prog_clk(pclk),
    .prog_din(pdin));
  pac_top #(.BREAK_CYC(20'h007D0), .EXIT_CYC(20'h003E8), .POLL_CYC(32'h1F4),
    .SECOND_CYC(32'h64)) dut_u (.MCLK(mclk), .EXTERNAL_RESET_INPUT(external_reset_input), .EXT_RESET_IN(pin),
    .PROG_ENABLE_N(pe_n), .PROG_CLOCK_IN(pclk), .PROG_DATA_IN(pdin), .PROG_DATA_OUT(pdout),
    .TEST_MODE(test_m), .PROG_MODE(prog_m), .WM_UNLOCKED(wm_unl), .WM_KEY_REF(wm_key),
    .ISP_KEY_REF(isp_key), .BOOT_TAIL(tail), .WAIT_BYTE(wait_b), .TWOWIRE_CLK1_PAD(pad1),
    .TWOWIRE_CLK2_PAD(pad2), .ISP_REQUEST(req), .ISP_CMD_VALID(valid), .ISP_CMD(cmd),
    .ISP_ARG(arg), .ISP_ACCEPT(acc), .ISP_REFUSE(rfs), .ISP_UNLOCKED(isp_unl),
    .BOOT_TO_USER(to_user), .BOOT_TO_ISP(to_isp), .FLASH_ERASE_MAIN(ers_main),
    .FLASH_ERASE_ALL(ers_all), .FLASH_CMD(fcmd), .FLASH_CMD_CODE(fcode),
    .FLASH_INFO_WR(info_wr), .FLASH_INFO_ADDR(faddr), .FLASH_INFO_DATA(fdata));
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // strobe counters and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    n_main <= n_main + {7'h0, ers_main};
    n_all <= n_all + {7'h0, ers_all};
    n_cmd <= n_cmd + {7'h0, fcmd};
    n_info <= n_info + {7'h0, info_wr};
    if (cyc == 60000) begin
      error_cnt++;
      summarize();
    end
  end
  // oldest note against each isp answer
  always @(posedge mclk) begin
    if (acc === 1'b1 || rfs === 1'b1) begin
      check({acc, rfs}, notes.size() ? notes.pop_front() : 2'h0);
    end
  end
  task automatic do_reset;
    external_reset_input <= 1'b0;
    repeat (16) @(posedge mclk);
    check({test_m, prog_m, wm_unl, isp_unl, to_user, to_isp, pdout}, 7'h0);
    external_reset_input <= 1'b1;
  endtask
  task automatic isp(input logic [7:0] c, input logic [63:0] a, input logic [1:0] e);
    @(posedge mclk);
    valid <= 1'b1;
    cmd <= c;
    arg <= a;
    notes.push_back(e);
    @(posedge mclk) valid <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  initial begin
    seed = 32'hEACC31F8;
    {valid, cmd, arg, req, external_reset_input, pad2, wait_b} = {1'b0, 8'h00, 64'h0, 3'h0, 1'b0, 1'b1, 8'h87};
    {pad1, wm_key} = {1'b1, {64{1'b1}}}; // erased key location reads all ones
    {n_main, n_all, n_cmd, n_info} = 32'h0;
    isp_key = {$random(seed), $random(seed)};
    tail = {$random(seed), 96'h0};
    do_reset;
    settle(12);
    check({to_user, to_isp}, 2'h2);
    // bad byte, retry without break, then a clean test entry
    prog_u.entry(1'b1, 16'hA500);
    settle(20);
    check({test_m, prog_m}, 2'h0);
    prog_u.entry(1'b0, 16'hA53C);
    settle(20);
    check({test_m, prog_m}, 2'h0);
    prog_u.entry(1'b1, 16'hA53C);
    settle(20);
    check({test_m, prog_m}, 2'h2);
    prog_u.hold_high(900);
    check(test_m, 1'b1);
    prog_u.hold_high(200);
    check(test_m, 1'b0);
    // writer mode: locked port forwards only erases
    prog_u.entry(1'b1, 16'hA5C3);
    settle(20);
    check({test_m, prog_m}, 2'h1);
    prog_u.en(1'b0);
    settle(4);
    prog_u.send_byte(8'h05);
    prog_u.reframe;
    prog_u.send_byte(8'h01);
    prog_u.reframe;
    prog_u.send_byte(8'h02);
    settle(10);
    check({n_cmd, n_main, n_all}, 24'h000101);
    prog_u.reframe;
    prog_u.send_byte(8'h03);
    // ninth byte lands while the verify runs and reads the busy bit
    repeat (9) prog_u.send_byte(8'hFF);
    check(pdout, 1'b1);
    settle(1820);
    check(wm_unl, 1'b0);
    settle(200);
    check(wm_unl, 1'b1);
    // maker byte 39 sits below the MU base, so it needs the earlier erase-all
    prog_u.reframe;
    prog_u.send_byte(8'h04);
    prog_u.send_byte(8'h39);
    prog_u.send_byte(8'hFF);
    settle(10);
    check({n_info, faddr, fdata}, 24'h0139FF);
    prog_u.reframe;
    prog_u.send_byte(8'h05);
    settle(10);
    check({n_cmd, fcode}, 16'h0105);
    prog_u.en(1'b1);
    // blank tail: 3 s window runs out, then a request late in it
    tail <= {128{1'b1}};
    do_reset;
    settle(810);
    check({to_user, to_isp}, 2'h2);
    do_reset;
    settle(770);
    check({to_user, to_isp}, 2'h0);
    req <= 3'h1 << ($unsigned($random(seed)) % 3);
    settle(10);
    check(to_isp, 1'b1);
    req <= 3'h0;
    wait_b <= 8'h80;
    pad2 <= 1'b0;
    do_reset;
    settle(12);
    check(to_isp, 1'b1);
    isp(8'h01, 64'h0, 2'h1);
    isp(8'h03, isp_key, 2'h2);
    settle(2);
    check(isp_unl, 1'b1);
    isp(8'h04, 64'h1000, 2'h1);
    isp(8'h04, {48'h0, 8'h50, isp_key[7:0]}, 2'h2);
    settle(4);
    check({n_info, faddr, fdata}, {16'h0250, isp_key[7:0]});
    isp(8'h04, 64'h5000, 2'h1);
    settle(4);
    check({n_info, 2'(notes.size())}, 10'h008);
    summarize();
  end
endmodule // test_pac_top
`default_nettype wire
